// [verilog/rcr_pkg.sv]
`default_nettype none
package rcr_pkg;
  localparam int CODE_W = 16;
  localparam int DATA_W = 32;
  localparam int EXC_W = 8;
  localparam int ERR_W = 8;
  localparam logic [15:0] CMD_NONE = 16'h0000;
  localparam logic [15:0] CMD_SP1_ON = 16'h0001;
  localparam logic [15:0] CMD_SP1_OFF = 16'h0002;
  localparam logic [15:0] CMD_SP2_ON = 16'h0003;
  localparam logic [15:0] CMD_SP2_OFF = 16'h0004;
  localparam logic [15:0] CMD_SPB_ON = 16'h0005;
  localparam logic [15:0] CMD_SPB_OFF = 16'h0006;
  localparam logic [15:0] CMD_TARE = 16'h0007;
  localparam logic [15:0] CMD_ZERO = 16'h0008;
  localparam logic [15:0] CMD_GROSS = 16'h0009;
  localparam logic [15:0] CMD_NET = 16'h000A;
  localparam logic [15:0] CMD_SHUNT_OFF = 16'h000B;
  localparam logic [15:0] CMD_SHUNT_ON = 16'h000C;
  localparam logic [15:0] CMD_SHOW_WT = 16'h000D;
  localparam logic [15:0] CMD_SHOW_FLOW = 16'h000E;
  localparam logic [15:0] CMD_START = 16'h0010;
  localparam logic [15:0] CMD_REM_ON = 16'h0011;
  localparam logic [15:0] CMD_REM_OFF = 16'h0012;
  localparam logic [15:0] CMD_PRINT = 16'h0013;
  localparam logic [15:0] CMD_BATCH_LO = 16'h0032;
  localparam logic [15:0] CMD_BATCH_HI = 16'h003C;
  localparam logic [15:0] CMD_SETUP = 16'h0064;
  localparam logic [15:0] CMD_RESTORE = 16'h0065;
  localparam logic [15:0] CMD_SAVE = 16'h0066;
  localparam logic [15:0] CMD_DISCARD = 16'h0067;
  localparam logic [15:0] CMD_RESET = 16'h0068;
  localparam logic [15:0] CMD_CHECK = 16'h0069;
  localparam logic [7:0] EXC_ILLEGAL = 8'h03;
  localparam logic [7:0] EXC_NAK = 8'h07;
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_UNKNOWN = 8'h01;
  localparam logic [7:0] ERR_STATE = 8'h02;
  localparam logic [7:0] ERR_OPTION = 8'h03;
  localparam logic [7:0] ERR_SESSION = 8'h04;
  localparam logic RD_SEL_CMD = 1'b0;
  localparam logic RD_SEL_SIG = 1'b1;
  typedef enum logic [1:0] {SS_IDLE, SS_SETUP, SS_RESTORE} rcr_sess_t;
endpackage : rcr_pkg
`default_nettype wire

// [verilog/rcr_top.sv]
// Function
// RULE1: Reading the command register always returns zero.
// RULE2: A nonzero code triggers exactly its one action; code 0 does nothing.
// RULE3: A command that cannot be performed is answered by an exception.
// RULE4: After exception 03 or 07 a detailed cause is readable.
// RULE5: Codes 1-6 activate or deactivate setpoint one, two or both.
// RULE6: 7 tares, 8 zeroes gross, 9 selects gross, 10 selects net.
// RULE7: 11/12 disconnect/connect shunt; 13/14 show weight/flow rate (option).
// RULE8: Code 16 starts the instrument from its start-waiting state.
// RULE9: Code 17 enters remote operation and locks the front-panel keys.
// RULE10: Code 17 accepted only while weight or batching screen shows.
// RULE11: Code 18 leaves remote operation and unlocks the keys.
// RULE12: Code 19 starts a printout.
// RULE13: Codes 50-60 go to the batching option.
// RULE14: Code 100 enters a remote set-up session.
// RULE15: Code 101 enters a remote restore session.
// RULE16: Code 102 ends the session and stores the parameters.
// RULE17: Code 103 leaves set-up discarding edits.
// RULE18: Code 104 resets the instrument.
// RULE19: Code 105 checks the set-up data.
// RULE20: Codes 100-104 suspend normal weighing.
// RULE21: Input signal reads load ratio, or shunt change while shunt connected.
// RULE22: Unassigned codes are refused with an exception.
// RULE23: Each accepted write fires its action once; no code stays pending.
`timescale 1ns/1ps
`default_nettype none
module rcr_top (
  input wire logic mclk, // 10 MHz clock
  input wire logic rstn, // Async reset
  input wire logic clk_en, // Freezes all state when low
  input wire logic wr_stb, // Command write strobe
  input wire logic [rcr_pkg::CODE_W-1:0] wr_code, // Written command code
  input wire logic rd_stb, // Register read strobe
  input wire logic rd_sel, // 0 command, 1 input signal
  input wire logic [rcr_pkg::DATA_W-1:0] load_ratio, // Load-cell ratio
  input wire logic [rcr_pkg::DATA_W-1:0] shunt_delta, // Shunt-induced change
  input wire logic show_weight, // Weight screen shown
  input wire logic batch_screen, // Batching screen shown
  input wire logic wait_start, // Waiting for start
  input wire logic flow_opt, // Flow rate option present
  input wire logic batch_opt, // Batching option present
  output logic ack, // Normal reply pulse
  output logic exc, // Exception reply pulse
  output logic [rcr_pkg::EXC_W-1:0] exc_code, // Exception code
  output logic [rcr_pkg::ERR_W-1:0] cmd_err, // Detailed failure cause
  output logic rd_vld, // Read data valid pulse
  output logic [rcr_pkg::DATA_W-1:0] rd_data, // Read data
  output logic act_stb, // Action pulse
  output logic [rcr_pkg::CODE_W-1:0] act_code, // Action being started
  output logic batch_stb, // Batching command pulse
  output logic rst_req, // Instrument reset pulse
  output logic [1:0] sp_on, // Setpoint 2..1 active
  output logic net_mode, // Net weighing selected
  output logic shunt_on, // Shunt resistor connected
  output logic flow_disp, // Flow rate on display
  output logic remote, // Remote operation
  output logic keys_en, // Front-panel keys enabled
  output logic [1:0] sess, // Set-up session state
  output logic suspend // Normal weighing suspended
);
  import rcr_pkg::*;
  function automatic logic is_batch(input logic [CODE_W-1:0] c);
    return (c >= CMD_BATCH_LO) && (c <= CMD_BATCH_HI);
  endfunction : is_batch
  function automatic logic is_known(input logic [CODE_W-1:0] c);
    return (c <= CMD_SHOW_FLOW) || (c >= CMD_START && c <= CMD_PRINT) ||
           is_batch(c) || (c >= CMD_SETUP && c <= CMD_CHECK);
  endfunction : is_known
  logic ack_reg, ack_next;
  logic exc_reg, exc_next;
  logic [EXC_W-1:0] exc_code_reg, exc_code_next;
  logic [ERR_W-1:0] err_reg, err_next;
  logic rd_vld_reg, rd_vld_next;
  logic [DATA_W-1:0] rd_data_reg, rd_data_next;
  logic act_stb_reg, act_stb_next;
  logic [CODE_W-1:0] act_code_reg, act_code_next;
  logic batch_stb_reg, batch_stb_next;
  logic rst_req_reg, rst_req_next;
  logic [1:0] sp_reg, sp_next;
  logic net_reg, net_next;
  logic shunt_reg, shunt_next;
  logic flow_reg, flow_next;
  logic remote_reg, remote_next;
  logic keys_reg, keys_next;
  rcr_sess_t sess_reg, sess_next;
  logic susp_reg, susp_next;

  always_comb
  begin
    logic f_unk;
    logic f_st;
    logic f_opt;
    logic f_ses;
    f_unk = 1'b0;
    f_st = 1'b0;
    f_opt = 1'b0;
    f_ses = 1'b0;
    ack_next = 1'b0;
    exc_next = 1'b0;
    exc_code_next = exc_code_reg;
    err_next = err_reg;
    act_stb_next = 1'b0;
    act_code_next = act_code_reg;
    batch_stb_next = 1'b0;
    rst_req_next = 1'b0;
    sp_next = sp_reg;
    net_next = net_reg;
    shunt_next = shunt_reg;
    flow_next = flow_reg;
    remote_next = remote_reg;
    keys_next = keys_reg;
    sess_next = sess_reg;
    rd_vld_next = rd_stb;
    rd_data_next = rd_data_reg;
    if (rd_stb)
    begin
      if (rd_sel == RD_SEL_CMD)
        rd_data_next = '0; // [RULE1]
      else
        rd_data_next = shunt_reg ? shunt_delta : load_ratio; // [RULE21]
    end
    if (wr_stb)
    begin
      case (wr_code)
        CMD_NONE: ;
        CMD_SP1_ON: sp_next[0] = 1'b1; // [RULE5]
        CMD_SP1_OFF: sp_next[0] = 1'b0; // [RULE5]
        CMD_SP2_ON: sp_next[1] = 1'b1; // [RULE5]
        CMD_SP2_OFF: sp_next[1] = 1'b0; // [RULE5]
        CMD_SPB_ON: sp_next = 2'h3; // [RULE5]
        CMD_SPB_OFF: sp_next = 2'h0; // [RULE5]
        CMD_GROSS: net_next = 1'b0; // [RULE6]
        CMD_NET: net_next = 1'b1; // [RULE6]
        CMD_SHUNT_OFF: shunt_next = 1'b0; // [RULE7]
        CMD_SHUNT_ON: shunt_next = 1'b1; // [RULE7]
        CMD_SHOW_WT: flow_next = 1'b0; // [RULE7]
        CMD_SHOW_FLOW:
        begin
          if (!flow_opt)
            f_opt = 1'b1;
          else
            flow_next = 1'b1; // [RULE7]
        end
        CMD_START: f_st = !wait_start; // [RULE8]
        CMD_REM_ON:
        begin
          if (!(show_weight || batch_screen))
            f_st = 1'b1; // [RULE10]
          else
          begin
            remote_next = 1'b1; // [RULE9]
            keys_next = 1'b0; // [RULE9]
          end
        end
        CMD_REM_OFF:
        begin
          remote_next = 1'b0; // [RULE11]
          keys_next = 1'b1; // [RULE11]
        end
        CMD_SETUP, CMD_RESTORE:
        begin
          // A second session on top of an open one would lose its edits
          if (sess_reg != SS_IDLE)
            f_ses = 1'b1;
          else if (wr_code == CMD_SETUP)
            sess_next = SS_SETUP; // [RULE14]
          else
            sess_next = SS_RESTORE; // [RULE15]
        end
        CMD_SAVE, CMD_DISCARD:
        begin
          if (sess_reg == SS_IDLE)
            f_ses = 1'b1;
          else
            sess_next = SS_IDLE; // [RULE16] [RULE17]
        end
        CMD_RESET:
        begin
          rst_req_next = 1'b1; // [RULE18]
          sess_next = SS_IDLE;
        end
        default:
        begin
          if (!is_known(wr_code))
            f_unk = 1'b1; // [RULE22]
          else if (is_batch(wr_code) && !batch_opt)
            f_opt = 1'b1;
        end
      endcase
      if (f_unk)
      begin
        exc_next = 1'b1; // [RULE3]
        exc_code_next = EXC_ILLEGAL;
        err_next = ERR_UNKNOWN; // [RULE4]
      end
      else if (f_st || f_opt || f_ses)
      begin
        exc_next = 1'b1; // [RULE3]
        exc_code_next = EXC_NAK;
        err_next = f_st ? ERR_STATE : (f_opt ? ERR_OPTION : ERR_SESSION); // [RULE4]
      end
      else
      begin
        ack_next = 1'b1;
        err_next = ERR_NONE;
        // Tare, zero, start, print and check exist only as this pulse
        act_stb_next = (wr_code != CMD_NONE); // [RULE2] [RULE12] [RULE19] [RULE23]
        act_code_next = wr_code;
        batch_stb_next = is_batch(wr_code); // [RULE13]
      end
    end
    susp_next = (sess_next != SS_IDLE) || rst_req_next ||
                (ack_next && (wr_code == CMD_SAVE || wr_code == CMD_DISCARD)); // [RULE20]
    if (f_unk || f_st || f_opt || f_ses)
    begin
      sp_next = sp_reg;
      sess_next = sess_reg;
      susp_next = susp_reg;
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      ack_reg <= 1'b0;
      exc_reg <= 1'b0;
      exc_code_reg <= 8'h00;
      err_reg <= ERR_NONE;
      rd_vld_reg <= 1'b0;
      rd_data_reg <= 32'h0000_0000;
      act_stb_reg <= 1'b0;
      act_code_reg <= CMD_NONE;
      batch_stb_reg <= 1'b0;
      rst_req_reg <= 1'b0;
      sp_reg <= 2'h0;
      net_reg <= 1'b0;
      shunt_reg <= 1'b0;
      flow_reg <= 1'b0;
      remote_reg <= 1'b0;
      keys_reg <= 1'b1;
      sess_reg <= SS_IDLE;
      susp_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      ack_reg <= ack_next;
      exc_reg <= exc_next;
      exc_code_reg <= exc_code_next;
      err_reg <= err_next;
      rd_vld_reg <= rd_vld_next;
      rd_data_reg <= rd_data_next;
      act_stb_reg <= act_stb_next;
      act_code_reg <= act_code_next;
      batch_stb_reg <= batch_stb_next;
      rst_req_reg <= rst_req_next;
      sp_reg <= sp_next;
      net_reg <= net_next;
      shunt_reg <= shunt_next;
      flow_reg <= flow_next;
      remote_reg <= remote_next;
      keys_reg <= keys_next;
      sess_reg <= sess_next;
      susp_reg <= susp_next;
    end
  end

  assign ack = ack_reg;
  assign exc = exc_reg;
  assign exc_code = exc_code_reg;
  assign cmd_err = err_reg;
  assign rd_vld = rd_vld_reg;
  assign rd_data = rd_data_reg;
  assign act_stb = act_stb_reg;
  assign act_code = act_code_reg;
  assign batch_stb = batch_stb_reg;
  assign rst_req = rst_req_reg;
  assign sp_on = sp_reg;
  assign net_mode = net_reg;
  assign shunt_on = shunt_reg;
  assign flow_disp = flow_reg;
  assign remote = remote_reg;
  assign keys_en = keys_reg;
  assign sess = sess_reg;
  assign suspend = susp_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic wr_go;
  assign wr_go = wr_stb && clk_en;

  cmd_read_zero_a: // [RULE1]
    assert property (rd_stb && clk_en && rd_sel == RD_SEL_CMD |=> rd_vld && rd_data == '0)
      else $error("command register read not zero");
  code_zero_quiet_a: // [RULE2]
    assert property (wr_go && wr_code == CMD_NONE |=> ack && !act_stb && !exc)
      else $error("code zero triggered something");
  one_reply_a: // [RULE3]
    assert property (wr_go |=> (ack ^ exc) && (exc == !act_stb || act_code == CMD_NONE))
      else $error("write not answered by exactly one reply");
  err_cause_a: // [RULE4]
    assert property (exc |-> cmd_err != ERR_NONE && (exc_code == EXC_ILLEGAL || exc_code == EXC_NAK))
      else $error("exception without cause");
  sp_both_a: // [RULE5]
    assert property (wr_go && wr_code == CMD_SPB_ON |=> sp_on == 2'h3 && act_stb)
      else $error("setpoints not both active");
  net_sel_a: // [RULE6]
    assert property (wr_go && wr_code == CMD_NET ##1 clk_en && !wr_stb |=> net_mode)
      else $error("net mode not held");
  start_gate_a: // [RULE8]
    assert property (wr_go && wr_code == CMD_START && !wait_start |=> exc && exc_code == EXC_NAK)
      else $error("start accepted outside wait state");
  remote_gate_a: // [RULE10]
    assert property (wr_go && wr_code == CMD_REM_ON && !show_weight && !batch_screen
                     |=> exc && $stable(remote) && cmd_err == ERR_STATE)
      else $error("remote entered from wrong state");
  remote_exit_a: // [RULE11]
    assert property (wr_go && wr_code == CMD_REM_OFF |=> !remote && keys_en)
      else $error("remote exit failed");
  sig_read_a: // [RULE21]
    assert property (rd_stb && clk_en && rd_sel == RD_SEL_SIG
                     |=> rd_data == ($past(shunt_on) ? $past(shunt_delta) : $past(load_ratio)))
      else $error("input signal read wrong source");
  reset_susp_a: // [RULE20]
    assert property (wr_go && wr_code == CMD_RESET |=> suspend && rst_req
                     ##1 clk_en && !(wr_stb && wr_code == CMD_RESET) |=> !rst_req)
      else $error("reset did not suspend once");
  unknown_code_a: // [RULE22]
    assert property (wr_go && !is_known(wr_code) |=> exc && exc_code == EXC_ILLEGAL && !act_stb)
      else $error("unassigned code accepted");
  one_shot_a: // [RULE23]
    assert property (act_stb && clk_en && !wr_stb |=> !act_stb)
      else $error("action pulse repeated");

  setup_cv: cover property (wr_go && wr_code == CMD_SETUP ##[1:20] wr_go && wr_code == CMD_SAVE);
  remote_cv: cover property (wr_go && wr_code == CMD_REM_ON ##1 remote);
  batch_cv: cover property (batch_stb);
  shunt_rd_cv: cover property (shunt_on && rd_stb && rd_sel == RD_SEL_SIG);
endmodule : rcr_top
`default_nettype wire

// [tb/rcr_master.sv]
`timescale 1ns/1ps
`default_nettype none
module rcr_master (
  input wire logic mclk, // Device clock
  input wire logic ack, // Normal reply
  input wire logic exc, // Exception reply
  input wire logic rd_vld, // Read reply
  input wire logic [rcr_pkg::DATA_W-1:0] rd_data, // Read reply data
  output logic wr_stb, // Write request
  output logic [rcr_pkg::CODE_W-1:0] wr_code, // Code to write
  output logic rd_stb, // Read request
  output logic rd_sel // Register picked for read
);
  import rcr_pkg::*;
  initial
  begin
    wr_stb = 1'b0;
    wr_code = CMD_NONE;
    rd_stb = 1'b0;
    rd_sel = RD_SEL_CMD;
  end
  // Idle gaps model a slow master; the reply is taken in the cycle it stands
  task automatic write_cmd(input logic [CODE_W-1:0] code, input int gap, output logic ok, output logic bad);
    repeat (gap) @(negedge mclk);
    wr_code = code;
    wr_stb = 1'b1;
    @(negedge mclk);
    wr_stb = 1'b0;
    wr_code = ~code; // Released bus must not look like the last code
    ok = ack;
    bad = exc;
  endtask : write_cmd
  task automatic read_reg(input logic sel, output logic vld, output logic [DATA_W-1:0] data);
    rd_sel = sel;
    rd_stb = 1'b1;
    @(negedge mclk);
    rd_stb = 1'b0;
    rd_sel = ~sel;
    vld = rd_vld;
    data = rd_data;
  endtask : read_reg
endmodule : rcr_master
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rcr_pkg::*;
  logic mclk, rstn, clk_en, wr_stb, rd_stb, rd_sel;
  logic show_weight, batch_screen, wait_start, flow_opt, batch_opt;
  logic [15:0] wr_code;
  logic [31:0] load_ratio, shunt_delta, rd_data;
  logic ack, exc, rd_vld, act_stb, batch_stb, rst_req, net_mode, shunt_on, flow_disp, remote, keys_en, suspend;
  logic [7:0] exc_code, cmd_err;
  logic [15:0] act_code;
  logic [1:0] sp_on, sess, sp, ss;
  logic net, sh, fl, rem, ok0, bad0;
  int n_fail, total_checks;
  rcr_top dut (.mclk(mclk), .rstn(rstn), .clk_en(clk_en), .wr_stb(wr_stb), .wr_code(wr_code), .rd_stb(rd_stb),
    .rd_sel(rd_sel), .load_ratio(load_ratio), .shunt_delta(shunt_delta), .show_weight(show_weight),
    .batch_screen(batch_screen), .wait_start(wait_start), .flow_opt(flow_opt), .batch_opt(batch_opt), .ack(ack),
    .exc(exc), .exc_code(exc_code), .cmd_err(cmd_err), .rd_vld(rd_vld), .rd_data(rd_data), .act_stb(act_stb),
    .act_code(act_code), .batch_stb(batch_stb), .rst_req(rst_req), .sp_on(sp_on), .net_mode(net_mode),
    .shunt_on(shunt_on), .flow_disp(flow_disp), .remote(remote), .keys_en(keys_en), .sess(sess), .suspend(suspend));
  rcr_master mst (.mclk(mclk), .ack(ack), .exc(exc), .rd_vld(rd_vld), .rd_data(rd_data), .wr_stb(wr_stb),
    .wr_code(wr_code), .rd_stb(rd_stb), .rd_sel(rd_sel));
  always #50 mclk = ~mclk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  // Expected failure cause from the code and the status seen at the taking edge
  function automatic logic [7:0] cause(input logic [15:0] c);
    if (c == 16'h000F || (c > CMD_PRINT && c < CMD_BATCH_LO) || (c > CMD_BATCH_HI && c < CMD_SETUP) || c > CMD_CHECK)
      return ERR_UNKNOWN;
    if ((c == CMD_SHOW_FLOW && !flow_opt) || (c >= CMD_BATCH_LO && c <= CMD_BATCH_HI && !batch_opt))
      return ERR_OPTION;
    if ((c == CMD_START && !wait_start) || (c == CMD_REM_ON && !(show_weight || batch_screen)))
      return ERR_STATE;
    if (((c == CMD_SETUP || c == CMD_RESTORE) && ss != 2'h0) || ((c == CMD_SAVE || c == CMD_DISCARD) && ss == 2'h0))
      return ERR_SESSION;
    return ERR_NONE;
  endfunction : cause
  task automatic step(input logic [15:0] c, input logic rnd);
    logic ok, bad, vld, sel;
    logic [7:0] e;
    logic [31:0] d;
    if (rnd)
      {show_weight, batch_screen, wait_start, flow_opt, batch_opt} = 5'($urandom);
    load_ratio = $urandom;
    shunt_delta = $urandom;
    e = cause(c);
    mst.write_cmd(c, $urandom % 3, ok, bad);
    check(ok, e == ERR_NONE);
    check(bad, e != ERR_NONE);
    if (e != ERR_NONE)
    begin
      check(exc_code, e == ERR_UNKNOWN ? EXC_ILLEGAL : EXC_NAK);
      check(cmd_err, e);
      check(act_stb, 0);
    end
    else
    begin
      case (c)
        CMD_SP1_ON: sp[0] = 1'b1;
        CMD_SP1_OFF: sp[0] = 1'b0;
        CMD_SP2_ON: sp[1] = 1'b1;
        CMD_SP2_OFF: sp[1] = 1'b0;
        CMD_SPB_ON: sp = 2'h3;
        CMD_SPB_OFF: sp = 2'h0;
        CMD_GROSS: net = 1'b0;
        CMD_NET: net = 1'b1;
        CMD_SHUNT_OFF: sh = 1'b0;
        CMD_SHUNT_ON: sh = 1'b1;
        CMD_SHOW_WT: fl = 1'b0;
        CMD_SHOW_FLOW: fl = 1'b1;
        CMD_REM_ON: rem = 1'b1;
        CMD_REM_OFF: rem = 1'b0;
        CMD_SETUP: ss = SS_SETUP;
        CMD_RESTORE: ss = SS_RESTORE;
        CMD_SAVE, CMD_DISCARD, CMD_RESET: ss = SS_IDLE;
        default: ;
      endcase
      check(act_stb, c != CMD_NONE);
      check(cmd_err, ERR_NONE);
      if (c != CMD_NONE)
        check(act_code, c);
      check(batch_stb, c >= CMD_BATCH_LO && c <= CMD_BATCH_HI);
      check(rst_req, c == CMD_RESET);
    end
    check(sp_on, sp);
    check({net_mode, shunt_on, flow_disp}, {net, sh, fl});
    check({remote, keys_en}, {rem, ~rem});
    check(sess, ss);
    check(suspend, ss != 2'h0 || (e == ERR_NONE && c >= CMD_SAVE && c <= CMD_RESET));
    sel = 1'($urandom);
    mst.read_reg(sel, vld, d);
    check(vld, 1);
    check(d, sel ? (sh ? shunt_delta : load_ratio) : 32'h0000_0000);
    check(act_stb, 0);
  endtask : step
  logic [15:0] corner [13] = '{16'h0000, 16'h0011, 16'h000E, 16'h0032, 16'h0010, 16'h0066, 16'h000F,
    16'h0064, 16'h0064, 16'h0065, 16'h0068, 16'h0012, 16'hFFFF};
  initial
  begin
    mclk = 1'b0;
    rstn = 1'b0;
    clk_en = 1'b1;
    {show_weight, batch_screen, wait_start, flow_opt, batch_opt} = 5'h00;
    load_ratio = 32'h0000_0000;
    shunt_delta = 32'h0000_0000;
    {sp, ss, net, sh, fl, rem} = 8'h00;
    n_fail = 0;
    total_checks = 0;
    void'($urandom(35808));
    repeat (2) @(negedge mclk);
    rstn = 1'b1;
    check(keys_en, 1);
    check({ack, exc, act_stb, remote, suspend, sess, sp_on}, 0);
    foreach (corner[i])
      step(corner[i], 1'b0);
    $display("test corners done");
    // A write over an edge with the enable low must not be taken or kept pending
    clk_en = 1'b0;
    mst.write_cmd(CMD_SP1_ON, 0, ok0, bad0);
    clk_en = 1'b1;
    check({ok0, bad0, sp_on}, 0);
    @(negedge mclk);
    check({ack, act_stb, sp_on}, 0);
    $display("test enable done");
    repeat (500)
      step(($urandom % 8 == 0) ? CMD_REM_ON : 16'($urandom % 112), 1'b1);
    $display("test random done");
    rstn = 1'b0;
    @(negedge mclk);
    rstn = 1'b1;
    {sp, ss, net, sh, fl, rem} = 8'h00;
    check({keys_en, remote, sess, sp_on, net_mode, shunt_on, suspend}, 9'h100);
    step(CMD_SETUP, 1'b0);
    step(CMD_DISCARD, 1'b0);
    $display("test reset done");
    end_sim;
  end
  // Run needs about 1550 cycles; allow about thirteen times that
  initial
  begin
    #2000000;
    n_fail++;
    end_sim;
  end
endmodule : tb_top
`default_nettype wire
